/* verilog/ldo_option_regs.sv */
// Purpose: Option registers for floppy, parallel, serial and IR devices
// Assumes: Plain register port, read data valid the cycle after the strobe
// Notes: Drive select chooses which drive's options steer the pins
`timescale 1ns/10ps
`default_nettype none
module ldo_option_regs (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ldo_pkg::ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic drive_sel_i,
    input wire ldo_pkg::ldo_rate_in_t rate_in_i,
    output logic density_pin_zero_o,
    output logic density_pin_one_o,
    output logic precomp_en_o,
    output logic [1:0] rate_table_o,
    output logic [7:0] drive_types_o,
    output logic [2:0] pp_mode_o,
    output logic [3:0] pp_fifo_thresh_o,
    output logic [5:0] ecp_config_b_view_o,
    input wire logic printer_acknowledge_in_i,
    input wire logic pp_irq_event_i,
    output logic pp_irq_o,
    output logic pp_irq_oe_o,
    output logic [1:0] serial_mode_o,
    output logic [1:0] infrared_mode_o
);

    // Index of each drive's option byte; one generate slot per drive
    localparam logic [7:0] DRIVE_IDX [2] = '{
        ldo_pkg::IDX_DRIVE_ZERO,
        ldo_pkg::IDX_DRIVE_ONE
    };

    // One-hot states of the parallel interrupt driver
    typedef enum logic [2:0] {
        IRQ_FOLLOW = 3'b001,
        IRQ_RELEASED = 3'b010,
        IRQ_PULSE = 3'b100
    } ldo_irq_state_t;

    // Address decode
    wire logic [2:0] ldn;
    wire logic [7:0] index;
    wire logic floppy_dev;
    wire logic parallel_dev;
    wire logic serial_dev;
    wire logic infrared_dev;
    wire logic hit_types;
    wire logic hit_reserved;
    wire logic [1:0] hit_drive;
    wire logic hit_pp_mode;
    wire logic hit_pp_channel;
    wire logic hit_serial;
    wire logic hit_infrared;

    // Write enables
    wire logic wr_types;
    wire logic [1:0] wr_drive;
    wire logic wr_pp_mode;
    wire logic wr_pp_channel;
    wire logic wr_serial;
    wire logic wr_infrared;

    // Register state
    logic [7:0] drive_types_r;
    logic [7:0] drive_types_nxt;
    ldo_pkg::ldo_drive_opt_t drive_opt_r [2];
    ldo_pkg::ldo_drive_opt_t drive_opt_wdata;
    logic [7:0] pp_mode_r;
    logic [7:0] pp_mode_nxt;
    logic [5:0] pp_channel_r;
    logic [5:0] pp_channel_nxt;
    logic [1:0] serial_mode_r;
    logic [1:0] serial_mode_nxt;
    logic [1:0] infrared_mode_r;
    logic [1:0] infrared_mode_nxt;

    // Read path
    logic [7:0] read_value;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Selected drive and pin mapping
    ldo_pkg::ldo_drive_opt_t sel_opt;
    wire logic [1:0] sel_type;
    wire logic pin_zero_nxt;
    wire logic pin_one_nxt;
    logic density_zero_r;
    logic density_one_r;
    logic precomp_en_r;
    logic [1:0] rate_table_r;

    // Parallel interrupt driver
    wire logic [2:0] pp_mode_field;
    wire logic plain_mode;
    wire logic pulse_mode;
    ldo_irq_state_t irq_state_r;
    ldo_irq_state_t irq_state_nxt;
    logic pp_irq_r;
    logic pp_irq_oe_r;
    wire logic pp_irq_nxt;
    wire logic pp_irq_oe_nxt;

    // Device number sits above the 8-bit index
    assign ldn = addr_i[ldo_pkg::ADDR_W-1:8];
    assign index = addr_i[7:0];

    assign floppy_dev = (ldn == ldo_pkg::LDN_FLOPPY);
    assign parallel_dev = (ldn == ldo_pkg::LDN_PARALLEL);
    assign serial_dev = (ldn == ldo_pkg::LDN_SERIAL);
    assign infrared_dev = (ldn == ldo_pkg::LDN_INFRARED);

    assign hit_types = floppy_dev && (index == ldo_pkg::IDX_DRIVE_TYPES);
    assign hit_reserved = floppy_dev && (index == ldo_pkg::IDX_RESERVED);
    assign hit_pp_mode = parallel_dev && (index == ldo_pkg::IDX_MODE);
    assign hit_pp_channel = parallel_dev && (index == ldo_pkg::IDX_CHANNEL);
    assign hit_serial = serial_dev && (index == ldo_pkg::IDX_MODE);
    assign hit_infrared = infrared_dev && (index == ldo_pkg::IDX_MODE);

    assign wr_types = wr_i && hit_types;
    assign wr_drive = {2{wr_i}} & hit_drive;
    assign wr_pp_mode = wr_i && hit_pp_mode;
    assign wr_pp_channel = wr_i && hit_pp_channel;
    assign wr_serial = wr_i && hit_serial;
    assign wr_infrared = wr_i && hit_infrared;

    // Drive types: all eight bits are writable
    assign drive_types_nxt = wr_types ? wdata_i : drive_types_r;

    // Bit 7 is the interrupt type, bits 6:3 the FIFO threshold
    assign pp_mode_nxt = wr_pp_mode ? wdata_i : pp_mode_r;

    // Bits 7:6 have no storage, so writes there are lost by design
    assign pp_channel_nxt = wr_pp_channel ? wdata_i[5:0] :
        pp_channel_r;

    // Reserved mode bits are not kept; cheaper than storing them
    assign serial_mode_nxt = wr_serial ? wdata_i[1:0] :
        serial_mode_r;
    assign infrared_mode_nxt = wr_infrared ? wdata_i[1:0] :
        infrared_mode_r;

    // Read-only zero bits are masked before they reach storage
    assign drive_opt_wdata = wdata_i & ldo_pkg::DRIVE_OPT_MASK;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_drive
            ldo_pkg::ldo_drive_opt_t opt_nxt;
            assign hit_drive[g] = floppy_dev && (index == DRIVE_IDX[g]);
            assign opt_nxt = wr_drive[g] ? drive_opt_wdata :
                drive_opt_r[g];

            // Both drives share one layout and reset value
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    drive_opt_r[g] <= ldo_pkg::DRIVE_OPT_RST;
                end else begin
                    drive_opt_r[g] <= opt_nxt;
                end
            end

            opt_write_a: assert property (
                @(posedge clk_i) disable iff (!resetn_i)
                wr_drive[g] |=> drive_opt_r[g] == $past(drive_opt_wdata)
            ) else $error("Drive option write not stored");

            opt_rsvd_zero_a: assert property (
                @(posedge clk_i) disable iff (!resetn_i)
                rd_i && hit_drive[g] |=>
                    (rdata_o & ~ldo_pkg::DRIVE_OPT_MASK) == 8'h00
            ) else $error("Drive option reserved bit read as one");
        end
    endgenerate

    // First match wins; unmapped indexes read zero
    assign read_value =
        hit_types ? drive_types_r :
        hit_reserved ? 8'h00 :
        hit_drive[0] ? drive_opt_r[0] :
        hit_drive[1] ? drive_opt_r[1] :
        hit_pp_mode ? pp_mode_r :
        hit_pp_channel ? {2'h0, pp_channel_r} :
        hit_serial ? {6'h00, serial_mode_r} :
        hit_infrared ? {6'h00, infrared_mode_r} :
        8'h00;

    // Data stand only in the cycle after the strobe
    assign rdata_nxt = rd_i ? read_value : 8'h00;

    // Pins follow the drive picked by the select input
    assign sel_opt = drive_sel_i ? drive_opt_r[1] : drive_opt_r[0];
    assign sel_type = sel_opt.type_select;

    assign pin_zero_nxt =
        (sel_type == ldo_pkg::DT_DEN_R0) ? rate_in_i.density_select_level :
        (sel_type == ldo_pkg::DT_R1_R0) ? rate_in_i.rate_select_high :
        (sel_type == ldo_pkg::DT_NDEN_R0) ? !rate_in_i.density_select_level :
        rate_in_i.rate_select_low;
    assign pin_one_nxt =
        (sel_type == ldo_pkg::DT_R0_R1) ?
        rate_in_i.rate_select_high :
        rate_in_i.rate_select_low;

    // Interrupt type only matters outside printer and standard mode
    assign pp_mode_field = pp_mode_r[2:0];
    assign plain_mode = (pp_mode_field == ldo_pkg::PP_PRINTER) ||
        (pp_mode_field == ldo_pkg::PP_SPP);
    assign pulse_mode = pp_mode_r[ldo_pkg::PP_ITYPE_BIT] &&
        !plain_mode;

    always_comb begin
        irq_state_nxt = irq_state_r;
        case (irq_state_r)
            IRQ_FOLLOW: begin
                if (pulse_mode && pp_irq_event_i) begin
                    irq_state_nxt = IRQ_PULSE;
                end else if (pulse_mode) begin
                    irq_state_nxt = IRQ_RELEASED;
                end
            end
            IRQ_RELEASED: begin
                if (!pulse_mode) begin
                    irq_state_nxt = IRQ_FOLLOW;
                end else if (pp_irq_event_i) begin
                    irq_state_nxt = IRQ_PULSE;
                end
            end
            // A pulse lasts as long as the event input stays high, then the line floats
            IRQ_PULSE: begin
                if (!pulse_mode) begin
                    irq_state_nxt = IRQ_FOLLOW;
                end else if (!pp_irq_event_i) begin
                    irq_state_nxt = IRQ_RELEASED;
                end
            end
            default: begin
                irq_state_nxt = IRQ_FOLLOW;
            end
        endcase
    end

    // Driven low while pulsing, released between pulses; follows acknowledge otherwise
    assign pp_irq_oe_nxt = (irq_state_nxt != IRQ_RELEASED);
    assign pp_irq_nxt = (irq_state_nxt == IRQ_FOLLOW) &&
        printer_acknowledge_in_i;

    // Configuration registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            drive_types_r <= ldo_pkg::DRIVE_TYPES_RST;
            pp_mode_r <= ldo_pkg::PP_MODE_RST;
            pp_channel_r <= ldo_pkg::PP_CHANNEL_RST[5:0];
        end else begin
            drive_types_r <= drive_types_nxt;
            pp_mode_r <= pp_mode_nxt;
            pp_channel_r <= pp_channel_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_mode_r <= ldo_pkg::UART_MODE_RST[1:0];
            infrared_mode_r <= ldo_pkg::UART_MODE_RST[1:0];
        end else begin
            serial_mode_r <= serial_mode_nxt;
            infrared_mode_r <= infrared_mode_nxt;
        end
    end

    // Read data register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Pin side flops keep every output glitch free
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            density_zero_r <= 1'b0;
            density_one_r <= 1'b0;
            precomp_en_r <= 1'b1;
            rate_table_r <= 2'h0;
        end else begin
            density_zero_r <= pin_zero_nxt;
            density_one_r <= pin_one_nxt;
            precomp_en_r <= !sel_opt.precomp_off;
            rate_table_r <= sel_opt.rate_table;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_state_r <= IRQ_FOLLOW;
            pp_irq_r <= 1'b1;
            pp_irq_oe_r <= 1'b1;
        end else begin
            irq_state_r <= irq_state_nxt;
            pp_irq_r <= pp_irq_nxt;
            pp_irq_oe_r <= pp_irq_oe_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata_o = rdata_r;
    assign density_pin_zero_o = density_zero_r;
    assign density_pin_one_o = density_one_r;
    assign precomp_en_o = precomp_en_r;
    assign rate_table_o = rate_table_r;
    assign drive_types_o = drive_types_r;
    assign pp_mode_o = pp_mode_r[2:0];
    assign pp_fifo_thresh_o = pp_mode_r[6:3];
    assign ecp_config_b_view_o = pp_channel_r;
    assign pp_irq_o = pp_irq_r;
    assign pp_irq_oe_o = pp_irq_oe_r;
    assign serial_mode_o = serial_mode_r;
    assign infrared_mode_o = infrared_mode_r;

    types_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_types |=> drive_types_o == $past(wdata_i)
    ) else $error("Drive type write not stored");

    reserved_read_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        rd_i && hit_reserved |=> rdata_o == 8'h00
    ) else $error("Reserved index read nonzero");

    mode_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_pp_mode |=> pp_mode_o == $past(wdata_i[2:0]) &&
            pp_fifo_thresh_o == $past(wdata_i[6:3])
    ) else $error("Parallel mode write not stored");

    chan_top_zero_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        rd_i && hit_pp_channel |=> rdata_o[7:6] == 2'h0
    ) else $error("Channel top bits read nonzero");

    config_b_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_pp_channel |=> ecp_config_b_view_o == $past(wdata_i[5:0])
    ) else $error("Config B view does not track channel write");

    serial_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_serial |=> serial_mode_o == $past(wdata_i[1:0])
    ) else $error("Serial mode write not stored");

    ir_write_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        wr_infrared |=> infrared_mode_o == $past(wdata_i[1:0])
    ) else $error("Infrared mode write not stored");

    precomp_map_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        1'b1 |=> precomp_en_o == !$past(sel_opt.precomp_off)
    ) else $error("Precomp enable does not follow option");

    density_map_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        sel_type == ldo_pkg::DT_R1_R0 |=>
            density_pin_zero_o == $past(rate_in_i.rate_select_high) &&
            density_pin_one_o == $past(rate_in_i.rate_select_low)
    ) else $error("Density pins wrong for type one");

    density_inv_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        sel_type == ldo_pkg::DT_NDEN_R0 |=>
            density_pin_zero_o == !$past(rate_in_i.density_select_level)
    ) else $error("Density pin not inverted for type two");

    irq_pulse_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        pulse_mode && pp_irq_event_i |=> pp_irq_oe_o && !pp_irq_o
    ) else $error("Interrupt pulse not driven low");

    irq_release_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        pulse_mode && !pp_irq_event_i |=> !pp_irq_oe_o
    ) else $error("Interrupt line not released");

    irq_follow_a: assert property (
        @(posedge clk_i) disable iff (!resetn_i)
        !pulse_mode |=> pp_irq_oe_o &&
            pp_irq_o == $past(printer_acknowledge_in_i)
    ) else $error("Interrupt does not follow acknowledge");
endmodule : ldo_option_regs
`default_nettype wire

/* verilog/ldo_pkg.sv */
// Purpose: Constants and types for the logical device option registers
// Assumes: Address is {logical device number, 8-bit index}
// Notes: Functional notes below
`default_nettype none
package ldo_pkg;
    localparam int ADDR_W = 11;
    localparam logic [2:0] LDN_FLOPPY = 3'h0;
    localparam logic [2:0] LDN_PARALLEL = 3'h3;
    localparam logic [2:0] LDN_SERIAL = 3'h4;
    localparam logic [2:0] LDN_INFRARED = 3'h5;
    localparam logic [7:0] IDX_MODE = 8'hf0;
    localparam logic [7:0] IDX_CHANNEL = 8'hf1;
    localparam logic [7:0] IDX_DRIVE_TYPES = 8'hf2;
    localparam logic [7:0] IDX_RESERVED = 8'hf3;
    localparam logic [7:0] IDX_DRIVE_ZERO = 8'hf4;
    localparam logic [7:0] IDX_DRIVE_ONE = 8'hf5;
    localparam logic [7:0] DRIVE_TYPES_RST = 8'hff;
    localparam logic [7:0] DRIVE_OPT_RST = 8'h00;
    localparam logic [7:0] DRIVE_OPT_MASK = 8'h5b;
    localparam logic [7:0] PP_MODE_RST = 8'h3c;
    localparam logic [7:0] PP_CHANNEL_RST = 8'h00;
    localparam logic [7:0] PP_CHANNEL_MASK = 8'h3f;
    localparam logic [7:0] UART_MODE_RST = 8'h00;
    localparam logic [7:0] UART_MODE_MASK = 8'h03;
    localparam int PTS_BIT = 6;
    localparam int PP_ITYPE_BIT = 7;
    localparam logic [2:0] PP_PRINTER = 3'h4;
    localparam logic [2:0] PP_SPP = 3'h0;
    localparam logic [2:0] PP_EPP19 = 3'h1;
    localparam logic [2:0] PP_EPP17 = 3'h5;
    localparam logic [2:0] PP_ECP = 3'h2;
    localparam logic [2:0] PP_ECP_EPP19 = 3'h3;
    localparam logic [2:0] PP_ECP_EPP17 = 3'h7;
    localparam logic [1:0] DT_DEN_R0 = 2'h0;
    localparam logic [1:0] DT_R1_R0 = 2'h1;
    localparam logic [1:0] DT_NDEN_R0 = 2'h2;
    localparam logic [1:0] DT_R0_R1 = 2'h3;

    typedef struct packed {
        logic reserved7;
        logic precomp_off;
        logic reserved5;
        logic [1:0] rate_table;
        logic reserved2;
        logic [1:0] type_select;
    } ldo_drive_opt_t;

    typedef struct packed {
        logic density_select_level;
        logic rate_select_low;
        logic rate_select_high;
    } ldo_rate_in_t;
endpackage : ldo_pkg
`default_nettype wire

/* tb/tb_ldo_option_regs.sv */
// Purpose: Readback bench for the option register bank
// Assumes: Read data stand only in the cycle after the read strobe
// Notes: Pin side inputs are random noise; register checks only
`timescale 1ns/10ps
`default_nettype none
module tb_ldo_option_regs;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, rd_q = 0;
    logic [10:0] a = 0;
    logic [7:0] d = 0, rdata_o;
    logic [3:0] rnd = 0;
    logic [7:0] q[$];
    int mismatches = 0, check_count = 0, seed = 32'h1a47086d;
    localparam logic [10:0] AD[8] = '{11'h0f2, 11'h0f3, 11'h0f4, 11'h0f5,
        11'h3f0, 11'h3f1, 11'h4f0, 11'h5f0};
    // Write mask, then readback mask; serial and IR get zero reserved bits
    localparam logic [15:0] WM[8] = '{16'hffff, 16'hff00, 16'hff5b,
        16'hff5b, 16'hffff, 16'hff3f, 16'h03ff, 16'h03ff};
    ldo_option_regs dut (.clk_i, .resetn_i, .addr_i(a), .wdata_i(d), .wr_i,
        .rd_i, .rdata_o, .drive_sel_i(rnd[0]), .rate_in_i(rnd[3:1]),
        .printer_acknowledge_in_i(rnd[1]), .pp_irq_event_i(rnd[2]),
        .density_pin_zero_o(), .density_pin_one_o(), .precomp_en_o(),
        .rate_table_o(), .drive_types_o(), .pp_mode_o(), .pp_fifo_thresh_o(),
        .ecp_config_b_view_o(), .pp_irq_o(), .pp_irq_oe_o(),
        .serial_mode_o(), .infrared_mode_o());
    initial forever #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        rnd <= 4'($random(seed));
        rd_q <= rd_i;
        if (rd_q)
            check(rdata_o, q.pop_front());
    end
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t read %h want %h", $time, s, e);
        end
    endtask : check
    task automatic op(input logic [10:0] ad, input logic [7:0] v,
        input logic [1:0] s);
        @(posedge clk_i);
        {a, d, wr_i, rd_i} <= {ad, v, s};
    endtask : op
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict
    initial begin
        #50000;
        mismatches++;
        give_verdict();
    end
    initial begin
        logic [7:0] v;
        repeat (16) @(posedge clk_i);
        resetn_i <= 1;
        // Reset values: ff, 00, 00, 00, 3c, 00, 00, 00
        for (int i = 0; i < 8; i++) begin
            q.push_back(i == 0 ? 8'hff : (i == 4 ? 8'h3c : 8'h00));
            op(AD[i], 8'h00, 2'b01);
        end
        for (int i = 0; i < 8; i++) begin
            repeat (16) begin
                v = 8'($random(seed)) & WM[i][15:8];
                op(AD[i], v, 2'b10);
                q.push_back(v & WM[i][7:0]);
                op(AD[i], 8'h00, 2'b01);
            end
        end
        op(11'h000, 8'h00, 2'b00);
        repeat (3) @(posedge clk_i);
        give_verdict();
    end
endmodule : tb_ldo_option_regs
`default_nettype wire
